// file: design/integration_test_registers.sv
`timescale 1ns/1ps
module integration_test_registers
   import itr_pkg::*;
#(
   parameter bit TWO_INTERFACES  = 1'b1,
   parameter bit INTEGRATION_CFG = 1'b1
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   // controller held in reset
   input  wire logic                  ctrl_in_reset,
   // peripheral register port
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   // controller inputs and outputs
   input  wire itr_pkg::ctrl_inputs_s  pin_inputs,
   input  wire itr_pkg::ctrl_outputs_s func_outputs,
   output      itr_pkg::ctrl_outputs_s ctrl_outputs,
   // present state of the test enable
   output      logic                  test_mode
);
   import itr_pkg::*;

   // synchronised pin inputs
   ctrl_inputs_s  in_clean;
   // access sequencer
   access_state_e state_r;
   access_state_e state_nxt;
   logic          pready_r;
   logic          pready_nxt;
   // test enable and forcing register
   logic          test_en_r;
   logic          test_en_nxt;
   logic [8:0]    force_r;
   logic [8:0]    force_nxt;
   // read data and controller outputs
   logic [31:0]   prdata_r;
   logic [31:0]   prdata_nxt;
   ctrl_outputs_s outs_r;
   ctrl_outputs_s outs_nxt;
   // decoded access strobes
   logic          hit;
   logic          access_cycle;
   logic          wr_cycle;
   logic          rd_cycle;
   logic          wr_config;
   logic          wr_driver;
   logic          rd_config;
   logic          rd_sampler;

   input_sync u_sync (
      .clk   (clk),
      .nrst  (nrst),
      .raw   (pin_inputs),
      .clean (in_clean)
   );

   // bits that exist in this build
   function automatic logic [9:0] in_mask();
      return TWO_INTERFACES ? 10'h3ff : IN_MASK_ONE_IF;
   endfunction

   function automatic logic [8:0] out_mask();
      return TWO_INTERFACES ? 9'h1ff : OUT_MASK_ONE_IF;
   endfunction

   // register decode, shared by the write and read paths
   function automatic logic reg_is(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction

   // sampler word: implemented pin bits, upper bits read as zero
   function automatic logic [31:0] sampler_word(input ctrl_inputs_s v);
      logic [31:0] w;
      w      = 32'h0000_0000;
      w[9:0] = v & in_mask();
      return w;
   endfunction

   // config word: enable at bit 0, all other bits read as zero
   function automatic logic [31:0] config_word(input logic en);
      logic [31:0] w;
      w              = 32'h0000_0000;
      w[TEST_EN_BIT] = en;
      return w;
   endfunction

   // block acts on accesses only when implemented and controller out of reset; ready is given either way
   assign hit          = INTEGRATION_CFG && !ctrl_in_reset;
   assign access_cycle = (state_r == ACC_SETUP);
   assign wr_cycle     = access_cycle && hit && pwrite;
   assign rd_cycle     = access_cycle && hit && !pwrite;
   assign wr_config    = wr_cycle && reg_is(paddr, OFS_TEST_CONFIG);
   assign wr_driver    = wr_cycle && reg_is(paddr, OFS_OUTPUT_DRIVER);
   assign rd_config    = rd_cycle && reg_is(paddr, OFS_TEST_CONFIG);
   assign rd_sampler   = rd_cycle && reg_is(paddr, OFS_INPUT_SAMPLER);

   // setup, access, then one idle cycle before the next setup is seen
   always_comb begin
      state_nxt  = state_r;
      pready_nxt = 1'b0;
      case (state_r)
         ACC_IDLE: begin
            if (psel && !penable) begin
               state_nxt = ACC_SETUP;
            end
         end
         ACC_SETUP: begin
            state_nxt  = ACC_DONE;
            pready_nxt = 1'b1;
         end
         ACC_DONE: begin
            state_nxt = ACC_IDLE;
         end
         default: begin
            state_nxt = ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r  <= ACC_IDLE;
         pready_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         pready_r <= pready_nxt;
      end
   end

   // only bit 0 is stored; upper write bits are dropped
   always_comb begin
      test_en_nxt = test_en_r;
      if (wr_config) begin
         test_en_nxt = pwdata[TEST_EN_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         test_en_r <= TEST_EN_RESET;
      end else begin
         test_en_r <= test_en_nxt;
      end
   end

   // unimplemented interface 1 bits never hold a value
   always_comb begin
      force_nxt = force_r;
      if (wr_driver) begin
         force_nxt = pwdata[8:0] & out_mask();
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         force_r <= OUTPUTS_RESET;
      end else begin
         force_r <= force_nxt;
      end
   end

   // read data stands only in the ready cycle and is zero otherwise
   always_comb begin
      prdata_nxt = 32'h0000_0000;
      if (rd_config) begin
         prdata_nxt = config_word(test_en_r);
      end else if (rd_sampler) begin
         prdata_nxt = sampler_word(in_clean);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // output mux between functional logic and forced values
   always_comb begin
      if (test_en_r) begin
         outs_nxt = ctrl_outputs_s'(force_r & out_mask());
      end else begin
         outs_nxt = func_outputs;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         outs_r <= '0;
      end else begin
         outs_r <= outs_nxt;
      end
   end

   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign ctrl_outputs = outs_r;
   assign test_mode    = test_en_r;
endmodule

// file: design/itr_pkg.sv
package itr_pkg;
   localparam logic [11:0] OFS_TEST_CONFIG   = 12'h0e00;
   localparam logic [11:0] OFS_INPUT_SAMPLER = 12'h0e04;
   localparam logic [11:0] OFS_OUTPUT_DRIVER = 12'h0e08;
   localparam int          TEST_EN_BIT       = 0;
   localparam logic        TEST_EN_RESET     = 1'b0;
   localparam logic [8:0]  OUTPUTS_RESET     = 9'h000;
   // input sampler field positions
   localparam int IN_CSYSREQ   = 0;
   localparam int IN_USE_BUS   = 1;
   localparam int IN_GRANT0    = 2;
   localparam int IN_BACKOFF0  = 3;
   localparam int IN_ACLK_SYNC_HINT_0    = 4;
   localparam int IN_MEMCLK_SYNC_HINT_0    = 5;
   localparam int IN_GRANT1    = 6;
   localparam int IN_BACKOFF1  = 7;
   localparam int IN_ACLK_SYNC_HINT_1    = 8;
   localparam int IN_MEMCLK_SYNC_HINT_1    = 9;
   // output driver field positions
   localparam int OUT_CACTIVE  = 0;
   localparam int OUT_CSYSACK  = 1;
   localparam int OUT_REQ0     = 2;
   localparam int OUT_REQ1     = 3;
   localparam int OUT_IRQ      = 4;
   localparam int OUT_IFACE0   = 5;
   localparam int OUT_IFACE1   = 6;
   localparam int OUT_ECC0     = 7;
   localparam int OUT_ECC1     = 8;
   // implemented bits in a single-interface build
   localparam logic [9:0] IN_MASK_ONE_IF  = 10'h03f;
   localparam logic [8:0] OUT_MASK_ONE_IF = 9'h027;

   typedef struct packed {
      logic ecc_irq_1;
      logic ecc_irq_0;
      logic iface1_irq;
      logic iface0_irq;
      logic combined_irq;
      logic bus_request_1;
      logic bus_request_0;
      logic csysack;
      logic cactive;
   } ctrl_outputs_s;

   typedef struct packed {
      logic memclk_sync_hint_1;
      logic aclk_sync_hint_1;
      logic bus_backoff_1;
      logic bus_grant_1;
      logic memclk_sync_hint_0;
      logic aclk_sync_hint_0;
      logic bus_backoff_0;
      logic bus_grant_0;
      logic use_shared_bus;
      logic csysreq;
   } ctrl_inputs_s;

   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b00,
      ACC_SETUP = 2'b01,
      ACC_DONE  = 2'b10
   } access_state_e;
endpackage

// file: design/input_sync.sv
`timescale 1ns/1ps
module input_sync
   import itr_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // raw and filtered inputs
   input  wire itr_pkg::ctrl_inputs_s raw,
   output      itr_pkg::ctrl_inputs_s clean
);
   ctrl_inputs_s s1_r;
   ctrl_inputs_s s2_r;
   ctrl_inputs_s s3_r;
   ctrl_inputs_s clean_r;
   ctrl_inputs_s clean_nxt;

   // a bit changes once second and third stage agree
   always_comb begin
      clean_nxt = clean_r;
      for (int i = 0; i < $bits(ctrl_inputs_s); i++) begin
         if (s2_r[i] == s3_r[i]) begin
            clean_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         clean_r <= '0;
      end else begin
         s1_r    <= raw;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         clean_r <= clean_nxt;
      end
   end

   assign clean = clean_r;
endmodule

// file: tb/integration_test_registers_chk.sv
`timescale 1ns/1ps
module integration_test_registers_chk
   import itr_pkg::*;
(
   // clock and reset
   input wire logic                   clk,
   input wire logic                   nrst,
   // register port
   input wire logic                   ctrl_in_reset,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   // controller side
   input wire itr_pkg::ctrl_inputs_s  pin_inputs,
   input wire itr_pkg::ctrl_outputs_s func_outputs,
   input wire itr_pkg::ctrl_outputs_s ctrl_outputs,
   input wire logic                   test_mode
);
   import itr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_ready_late: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("ready not two cycles after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside ready");
   chk_reset_blocks: assert property (pready && $past(ctrl_in_reset) |->
      prdata == 32'h0000_0000 && $stable(test_mode))
      else $error("access taken in controller reset");
   chk_wo_read: assert property (pready && paddr == OFS_OUTPUT_DRIVER |-> prdata == 0)
      else $error("output register readable");
   chk_cfg_read: assert property (pready && !pwrite && paddr == OFS_TEST_CONFIG &&
      !$past(ctrl_in_reset) |-> prdata == {31'h0, test_mode})
      else $error("config read wrong");
   chk_in_upper: assert property (pready && paddr == OFS_INPUT_SAMPLER |->
      prdata[31:10] == 22'h0)
      else $error("input upper bits set");
   chk_mode_write: assert property ($changed(test_mode) |-> pready && pwrite &&
      paddr == OFS_TEST_CONFIG && test_mode == pwdata[TEST_EN_BIT])
      else $error("test enable changed without write");
   chk_func_pass: assert property (!test_mode ##1 !test_mode |->
      ctrl_outputs == $past(func_outputs))
      else $error("outputs not functional");
   cover property (pready && pwrite && paddr == OFS_OUTPUT_DRIVER);
   cover property (pready && $past(ctrl_in_reset));
   cover property ($rose(test_mode));
endmodule
bind integration_test_registers integration_test_registers_chk i_chk (.clk(clk), .nrst(nrst),
   .ctrl_in_reset(ctrl_in_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pin_inputs(pin_inputs), .func_outputs(func_outputs), .ctrl_outputs(ctrl_outputs),
   .test_mode(test_mode));

// file: tb/integration_test_registers_bench.sv
`timescale 1ns/1ps
module integration_test_registers_bench;
   import itr_pkg::*;
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   logic          ctrl_in_reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0000_0000, prdata, rd, seed = 32'hee80;
   logic          pready, test_mode;
   ctrl_inputs_s  pin_inputs = '0;
   ctrl_outputs_s func_outputs = '0, ctrl_outputs, forced;
   logic [31:0]   prdata_one, prdata_off, rd_one, rd_off;
   logic          pready_one, pready_off, test_mode_one, test_mode_off;
   ctrl_outputs_s ctrl_outputs_one, ctrl_outputs_off;
   int            err_total = 0, n_tests = 0;
   always #25 clk = ~clk;
   integration_test_registers i_integration_test_registers (.clk(clk), .nrst(nrst),
      .ctrl_in_reset(ctrl_in_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pin_inputs(pin_inputs), .func_outputs(func_outputs), .ctrl_outputs(ctrl_outputs),
      .test_mode(test_mode));
   // single-interface build
   integration_test_registers #(.TWO_INTERFACES(1'b0), .INTEGRATION_CFG(1'b1))
      i_integration_test_registers_one (.clk(clk), .nrst(nrst),
      .ctrl_in_reset(ctrl_in_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata_one), .pready(pready_one),
      .pin_inputs(pin_inputs), .func_outputs(func_outputs), .ctrl_outputs(ctrl_outputs_one),
      .test_mode(test_mode_one));
   // build without the test register block
   integration_test_registers #(.TWO_INTERFACES(1'b1), .INTEGRATION_CFG(1'b0))
      i_integration_test_registers_off (.clk(clk), .nrst(nrst),
      .ctrl_in_reset(ctrl_in_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata_off), .pready(pready_off),
      .pin_inputs(pin_inputs), .func_outputs(func_outputs), .ctrl_outputs(ctrl_outputs_off),
      .test_mode(test_mode_off));
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [31:0] exp_in(input ctrl_inputs_s v);
      return {22'h0, v};
   endfunction
   function logic [31:0] exp_in_one(input ctrl_inputs_s v);
      return {22'h0, v & IN_MASK_ONE_IF};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(negedge clk);
      psel = 1'b1; penable = 1'b0; pwrite = w; paddr = a; pwdata = d;
      @(negedge clk);
      penable = 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (pready !== 1'b1 && n < 4);
      chk(32'(pready), 32'h1);
      chk(32'({pready_one, pready_off}), 32'h3);
      r = prdata;
      rd_one = prdata_one;
      rd_off = prdata_off;
      // hold the request through the edge that samples ready
      @(negedge clk);
      psel = 1'b0; penable = 1'b0;
   endtask
   task summarize();
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #(50 * 4000);
      err_total++;
      summarize();
   end
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      chk(32'(test_mode), 32'h0);
      acc(1'b0, OFS_TEST_CONFIG, 32'h0, rd); chk(rd, 32'h0);
      repeat (4) begin
         seed = lfsr(seed); pin_inputs = seed[9:0]; func_outputs = seed[18:10];
         repeat (8) @(negedge clk);
         chk(32'(ctrl_outputs), 32'(func_outputs));
         acc(1'b0, OFS_INPUT_SAMPLER, 32'h0, rd);
         chk(rd, exp_in(pin_inputs));
         chk(rd_one, exp_in_one(pin_inputs));
         chk(rd_off, 32'h0);
         chk(32'(ctrl_outputs_off), 32'(func_outputs));
      end
      $display("inputs test done");
      acc(1'b1, OFS_TEST_CONFIG, 32'h1, rd); acc(1'b0, OFS_TEST_CONFIG, 32'h0, rd);
      chk(rd, 32'h1);
      chk(rd_one, 32'h1);
      chk(rd_off, 32'h0);
      chk(32'({test_mode_one, test_mode_off}), 32'h2);
      repeat (3) begin
         seed = lfsr(seed); forced = seed[8:0];
         acc(1'b1, OFS_OUTPUT_DRIVER, 32'(forced), rd);
         @(negedge clk);
         chk(32'(ctrl_outputs), 32'(forced));
         chk(32'(ctrl_outputs_one), 32'(forced & OUT_MASK_ONE_IF));
         chk(32'(ctrl_outputs_off), 32'(func_outputs));
         acc(1'b0, OFS_OUTPUT_DRIVER, 32'h0, rd); chk(rd, 32'h0);
      end
      $display("outputs test done");
      ctrl_in_reset = 1'b1;
      acc(1'b1, OFS_TEST_CONFIG, 32'h0, rd); acc(1'b0, OFS_TEST_CONFIG, 32'h0, rd);
      chk(rd, 32'h0);
      acc(1'b0, OFS_INPUT_SAMPLER, 32'h0, rd); chk(rd, 32'h0);
      chk(rd_one, 32'h0);
      ctrl_in_reset = 1'b0;
      acc(1'b0, OFS_TEST_CONFIG, 32'h0, rd); chk(rd, 32'h1);
      acc(1'b1, OFS_TEST_CONFIG, 32'h0, rd); acc(1'b1, OFS_OUTPUT_DRIVER, 32'h1ff, rd);
      repeat (2) @(negedge clk);
      chk(32'(ctrl_outputs), 32'(func_outputs));
      acc(1'b0, 12'he0c, 32'h0, rd); chk(rd, 32'h0);
      $display("refusal test done");
      summarize();
   end
endmodule
